// File: logic/bit_sampler.sv
`timescale 1ns/1ps
module bit_sampler (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic rx,
	input wire logic enable,
	input wire logic restart,
	output logic bit_stb,
	output logic bit_val
);
	lin_uart_pkg::sm_state_t state_q, state_d;
	logic [3:0] ph_q, ph_d;
	logic first_q, first_d, s_a_q, s_a_d, s_b_q, s_b_d, stb_q, stb_d, val_q, val_d;
	logic maj;

	// ----------------------------------------
	// Start search and 3-sample majority
	// ----------------------------------------
	assign maj = (s_a_q & s_b_q) | (s_a_q & rx) | (s_b_q & rx);

	// Phase counter keeps running so later bits share the start phase
	always_comb
	begin
		state_d = state_q;
		ph_d = ph_q;
		first_d = first_q;
		s_a_d = s_a_q;
		s_b_d = s_b_q;
		stb_d = 1'b0;
		val_d = val_q;
		if (!enable || restart)
			state_d = lin_uart_pkg::SM_IDLE;
		else
			unique case (state_q)
				lin_uart_pkg::SM_IDLE:
					if (tick && !rx)
					begin
						state_d = lin_uart_pkg::SM_RUN;
						ph_d = 4'h1; // Detecting tick is sample one of the bit
						first_d = 1'b1;
					end
				lin_uart_pkg::SM_RUN:
					if (tick)
					begin
						ph_d = ph_q + 4'h1;
						if (ph_q == lin_uart_pkg::SAMP_FIRST)
							s_a_d = rx;
						if (ph_q == lin_uart_pkg::SAMP_MID)
							s_b_d = rx;
						if (ph_q == lin_uart_pkg::SAMP_LAST)
						begin
							// A high start bit was a glitch, go back to hunting
							if (first_q && maj)
								state_d = lin_uart_pkg::SM_IDLE;
							else
							begin
								stb_d = 1'b1;
								val_d = maj;
								first_d = 1'b0;
							end
						end
					end
			endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= lin_uart_pkg::SM_IDLE;
			ph_q <= 4'h0;
			first_q <= 1'b0;
			s_a_q <= 1'b1;
			s_b_q <= 1'b1;
			stb_q <= 1'b0;
			val_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			ph_q <= ph_d;
			first_q <= first_d;
			s_a_q <= s_a_d;
			s_b_q <= s_b_d;
			stb_q <= stb_d;
			val_q <= val_d;
		end
	end

	assign bit_stb = stb_q;
	assign bit_val = val_q;

	sample_point_a: assert property (@(posedge aclk) disable iff (!aresetn)
		bit_stb |-> ($past(ph_q) == lin_uart_pkg::SAMP_LAST) && $past(tick) &&
			(bit_val == (($past(s_a_q) & $past(s_b_q)) | ($past(s_a_q) & $past(rx)) |
			($past(s_b_q) & $past(rx)))))
		else $error("bit value not taken from samples 8 to 10");
endmodule

// File: logic/lin_uart.sv
`timescale 1ns/1ps
module lin_uart (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rxd,
	output logic txd,
	output logic irq
);
	logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wmask, rd_mux;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [11:0] ctrl_q, ctrl_d;
	logic [15:0] baud_q, baud_d, bcnt_q, bcnt_d;
	logic wr_do, rd_do, wr_data_pulse, rd_data_pulse, tick, sbk_done, wake;
	logic [7:0] clr, status;
	logic lin, lin_slave, muted;
	logic [7:0] rx_data_q, rx_data_d;

	// ----------------------------------------
	// AXI4-Lite slave and control registers
	// ----------------------------------------
	assign lin = ctrl_q[lin_uart_pkg::CB_LIN];
	assign lin_slave = lin && ctrl_q[lin_uart_pkg::CB_FOLLOW];
	assign muted = lin_slave && ctrl_q[lin_uart_pkg::CB_MUTE];
	assign awready = !aw_q && !bvalid_q;
	assign wready = !w_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign wr_do = aw_q && w_q && !bvalid_q;
	assign rd_do = arvalid && !rvalid_q;
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign wr_data_pulse = wr_do && awaddr_q == lin_uart_pkg::OFS_DATA && wstrb_q[0];
	assign rd_data_pulse = rd_do && araddr == lin_uart_pkg::OFS_DATA;
	assign clr = (wr_do && awaddr_q == lin_uart_pkg::OFS_STATUS) ?
		(wdata_q[7:0] & wmask[7:0] & lin_uart_pkg::ST_W1C) : 8'h00;
	assign tick = bcnt_q == 16'h0000;

	// Read mux; unmapped words read zero with an error answer
	always_comb
	begin
		unique case (araddr)
			lin_uart_pkg::OFS_DATA: rd_mux = {24'h000000, rx_data_q};
			lin_uart_pkg::OFS_STATUS: rd_mux = {24'h000000, status};
			lin_uart_pkg::OFS_CTRL: rd_mux = {20'h00000, ctrl_q};
			lin_uart_pkg::OFS_BAUD: rd_mux = {16'h0000, baud_q};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Address and data may arrive in either order; write once both are held
	always_comb
	begin
		aw_d = aw_q;
		awaddr_d = awaddr_q;
		w_d = w_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q && !bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !rready;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		ctrl_d = ctrl_q;
		baud_d = baud_q;
		bcnt_d = tick ? baud_q : bcnt_q - 16'h0001;
		if (sbk_done)
			ctrl_d[lin_uart_pkg::CB_SBK] = 1'b0;
		if (wake)
			ctrl_d[lin_uart_pkg::CB_MUTE] = 1'b0;
		if (awvalid && awready)
		begin
			aw_d = 1'b1;
			awaddr_d = awaddr;
		end
		if (wvalid && wready)
		begin
			w_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		if (wr_do)
		begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (awaddr_q[7:4] == 4'h0 && awaddr_q[1:0] == 2'h0) ?
				lin_uart_pkg::RESP_OKAY : lin_uart_pkg::RESP_SLVERR;
			if (awaddr_q == lin_uart_pkg::OFS_CTRL)
				ctrl_d = (ctrl_d & ~wmask[11:0]) | (wdata_q[11:0] & wmask[11:0]);
			if (awaddr_q == lin_uart_pkg::OFS_BAUD)
				baud_d = (baud_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
		end
		if (rd_do)
		begin
			rvalid_d = 1'b1;
			rdata_d = rd_mux;
			rresp_d = (araddr[7:4] == 4'h0 && araddr[1:0] == 2'h0) ?
				lin_uart_pkg::RESP_OKAY : lin_uart_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q <= 1'b0;
			awaddr_q <= 8'h00;
			w_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= lin_uart_pkg::RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= lin_uart_pkg::RESP_OKAY;
			ctrl_q <= lin_uart_pkg::CTRL_RESET;
			baud_q <= lin_uart_pkg::BAUD_RESET;
			bcnt_q <= lin_uart_pkg::BAUD_RESET;
		end
		else
		begin
			aw_q <= aw_d;
			awaddr_q <= awaddr_d;
			w_q <= w_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			ctrl_q <= ctrl_d;
			baud_q <= baud_d;
			bcnt_q <= bcnt_d;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// ----------------------------------------
	// Transmitter: break and characters
	// ----------------------------------------
	lin_uart_pkg::tx_state_t tx_state_q, tx_state_d;
	logic [13:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_left_q, tx_left_d, tx_ph_q, tx_ph_d, brk_lows_q, brk_lows_d;
	logic [7:0] hold_q, hold_d;
	logic hold_full_q, hold_full_d, tc_q, tc_d, txd_q, txd_d, tx_bit_end;

	assign tx_bit_end = tick && tx_ph_q == lin_uart_pkg::PHASE_END;

	// Break wins over a pending byte, so the synch byte waits behind it
	always_comb
	begin
		tx_state_d = tx_state_q;
		tx_sh_d = tx_sh_q;
		tx_left_d = tx_left_q;
		tx_ph_d = tx_ph_q;
		hold_d = hold_q;
		hold_full_d = hold_full_q;
		tc_d = tc_q;
		sbk_done = 1'b0;
		brk_lows_d = brk_lows_q;
		unique case (tx_state_q)
			lin_uart_pkg::TX_IDLE:
				if (ctrl_q[lin_uart_pkg::CB_TEN])
				begin
					tx_ph_d = 4'h0;
					if (ctrl_q[lin_uart_pkg::CB_SBK])
					begin
						tx_state_d = lin_uart_pkg::TX_BREAK;
						tx_sh_d = {1'b1, 13'h0000};
						tx_left_d = lin_uart_pkg::BRK_TX_BITS;
						brk_lows_d = 4'h0;
					end
					else if (hold_full_q)
					begin
						tx_state_d = lin_uart_pkg::TX_CHAR;
						tx_sh_d = {4'hF, 1'b1, hold_q, 1'b0};
						tx_left_d = lin_uart_pkg::CHAR_BITS;
						hold_full_d = 1'b0;
					end
				end
			lin_uart_pkg::TX_BREAK, lin_uart_pkg::TX_CHAR:
			begin
				if (tick)
					tx_ph_d = tx_ph_q + 4'h1;
				if (tx_bit_end && tx_state_q == lin_uart_pkg::TX_BREAK && !txd_q)
					brk_lows_d = brk_lows_q + 4'h1;
				if (tx_bit_end)
				begin
					tx_sh_d = {1'b1, tx_sh_q[13:1]};
					tx_left_d = tx_left_q - 4'h1;
					if (tx_left_q == 4'h1)
					begin
						tx_state_d = lin_uart_pkg::TX_IDLE;
						sbk_done = tx_state_q == lin_uart_pkg::TX_BREAK;
						tc_d = !hold_full_q;
					end
				end
			end
		endcase
		if (wr_data_pulse)
		begin
			hold_d = wdata_q[7:0];
			hold_full_d = 1'b1;
			tc_d = 1'b0;
		end
		txd_d = (tx_state_d == lin_uart_pkg::TX_IDLE) ? 1'b1 : tx_sh_d[0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_state_q <= lin_uart_pkg::TX_IDLE;
			tx_sh_q <= 14'h3FFF;
			tx_left_q <= 4'h0;
			tx_ph_q <= 4'h0;
			hold_q <= 8'h00;
			hold_full_q <= 1'b0;
			tc_q <= 1'b1;
			txd_q <= 1'b1;
			brk_lows_q <= 4'h0;
		end
		else
		begin
			tx_state_q <= tx_state_d;
			tx_sh_q <= tx_sh_d;
			tx_left_q <= tx_left_d;
			tx_ph_q <= tx_ph_d;
			hold_q <= hold_d;
			hold_full_q <= hold_full_d;
			tc_q <= tc_d;
			txd_q <= txd_d;
			brk_lows_q <= brk_lows_d;
		end
	end

	assign txd = txd_q;

	// ----------------------------------------
	// Break detector, its own sampler
	// ----------------------------------------
	lin_uart_pkg::bk_state_t bk_state_q, bk_state_d;
	logic [3:0] zcnt_q, zcnt_d, need;
	logic b_stb, b_val, bk_found, bk_cancel;

	// Separate sampler so a break is seen even mid-character
	bit_sampler u_brk_sampler (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick),
		.rx(rxd),
		.enable(ctrl_q[lin_uart_pkg::CB_REN]),
		.restart(bk_found || bk_cancel),
		.bit_stb(b_stb),
		.bit_val(b_val)
	);

	assign need = ctrl_q[lin_uart_pkg::CB_BLEN] ? lin_uart_pkg::BRK_LONG : lin_uart_pkg::BRK_SHORT;

	always_comb
	begin
		bk_state_d = bk_state_q;
		zcnt_d = zcnt_q;
		bk_found = 1'b0;
		bk_cancel = 1'b0;
		if (b_stb)
			unique case (bk_state_q)
				lin_uart_pkg::BK_COUNT:
					if (b_val)
					begin
						bk_cancel = 1'b1;
						zcnt_d = 4'h0;
					end
					else if (zcnt_q + 4'h1 == need)
					begin
						bk_state_d = lin_uart_pkg::BK_DELIM;
						zcnt_d = 4'h0;
					end
					else
						zcnt_d = zcnt_q + 4'h1;
				lin_uart_pkg::BK_DELIM:
					if (b_val)
					begin
						bk_found = 1'b1;
						bk_state_d = lin_uart_pkg::BK_COUNT;
					end
			endcase
		if (!ctrl_q[lin_uart_pkg::CB_REN])
		begin
			bk_state_d = lin_uart_pkg::BK_COUNT;
			zcnt_d = 4'h0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bk_state_q <= lin_uart_pkg::BK_COUNT;
			zcnt_q <= 4'h0;
		end
		else
		begin
			bk_state_q <= bk_state_d;
			zcnt_q <= zcnt_d;
		end
	end

	// ----------------------------------------
	// Data receiver and header tracking
	// ----------------------------------------
	lin_uart_pkg::rx_state_t rx_state_q, rx_state_d;
	logic [3:0] rx_idx_q, rx_idx_d;
	logic [7:0] rx_sh_q, rx_sh_d;
	logic [1:0] hdr_ph_q, hdr_ph_d;
	logic receive_full_flag_q, receive_full_flag_d, fe_q, fe_d, ovr_q, ovr_d, bdf_q, bdf_d, hdf_q, hdf_d, pe_q, pe_d;
	logic d_stb, d_val, char_done, id_done;

	bit_sampler u_rx_sampler (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick),
		.rx(rxd),
		.enable(ctrl_q[lin_uart_pkg::CB_REN] && rx_state_q == lin_uart_pkg::RX_RUN),
		.restart(char_done || (bk_found && lin)),
		.bit_stb(d_stb),
		.bit_val(d_val)
	);

	assign char_done = d_stb && rx_idx_q == lin_uart_pkg::STOP_IDX;

	// Identifier check: low parity bit and inverted high parity bit
	function automatic logic parity_ok(input logic [7:0] id);
		parity_ok = (id[6] == (id[0] ^ id[1] ^ id[2] ^ id[4])) &&
			(id[7] == !(id[1] ^ id[3] ^ id[4] ^ id[5]));
	endfunction

	// Clears are applied first so a same-cycle event still sets its flag
	always_comb
	begin
		rx_state_d = rx_state_q;
		rx_idx_d = rx_idx_q;
		rx_sh_d = rx_sh_q;
		rx_data_d = rx_data_q;
		hdr_ph_d = hdr_ph_q;
		receive_full_flag_d = receive_full_flag_q && !rd_data_pulse;
		fe_d = fe_q && !clr[lin_uart_pkg::ST_FE];
		ovr_d = ovr_q && !clr[lin_uart_pkg::ST_OVR];
		bdf_d = bdf_q && !clr[lin_uart_pkg::ST_BDF];
		hdf_d = hdf_q && !clr[lin_uart_pkg::ST_HDF];
		pe_d = pe_q && !clr[lin_uart_pkg::ST_PE];
		id_done = 1'b0;
		wake = 1'b0;
		if (d_stb)
		begin
			rx_idx_d = char_done ? 4'h0 : rx_idx_q + 4'h1;
			if (rx_idx_q != 4'h0 && !char_done)
				rx_sh_d = {d_val, rx_sh_q[7:1]};
		end
		if (char_done)
		begin
			if (!muted)
			begin
				rx_data_d = rx_sh_q;
				ovr_d = ovr_d || (receive_full_flag_q && !rd_data_pulse);
				receive_full_flag_d = 1'b1;
				fe_d = fe_d || !d_val;
			end
			if (lin && !d_val)
				rx_state_d = lin_uart_pkg::RX_HALT;
			if (hdr_ph_q == lin_uart_pkg::HDR_SYNCH)
				hdr_ph_d = (d_val && rx_sh_q == lin_uart_pkg::SYNCH_BYTE) ?
					lin_uart_pkg::HDR_ID : lin_uart_pkg::HDR_NONE;
			if (hdr_ph_q == lin_uart_pkg::HDR_ID)
			begin
				hdr_ph_d = lin_uart_pkg::HDR_NONE;
				if (d_val)
				begin
					id_done = 1'b1;
					hdf_d = 1'b1;
					rx_data_d = rx_sh_q;
					pe_d = pe_d || (ctrl_q[lin_uart_pkg::CB_PARITY_CHECK_ENABLE] && !parity_ok(rx_sh_q));
					wake = muted;
				end
			end
		end
		if (bk_cancel || bk_found)
			rx_state_d = lin_uart_pkg::RX_RUN;
		if (bk_found && lin)
		begin
			bdf_d = 1'b1;
			rx_idx_d = 4'h0; // Fresh framing, a misaligned char would eat the synch
			if (lin_slave)
				hdr_ph_d = lin_uart_pkg::HDR_SYNCH;
		end
		if (!lin)
		begin
			rx_state_d = lin_uart_pkg::RX_RUN;
			hdr_ph_d = lin_uart_pkg::HDR_NONE;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_state_q <= lin_uart_pkg::RX_RUN;
			rx_idx_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_data_q <= 8'h00;
			hdr_ph_q <= lin_uart_pkg::HDR_NONE;
			receive_full_flag_q <= 1'b0;
			fe_q <= 1'b0;
			ovr_q <= 1'b0;
			bdf_q <= 1'b0;
			hdf_q <= 1'b0;
			pe_q <= 1'b0;
		end
		else
		begin
			rx_state_q <= rx_state_d;
			rx_idx_q <= rx_idx_d;
			rx_sh_q <= rx_sh_d;
			rx_data_q <= rx_data_d;
			hdr_ph_q <= hdr_ph_d;
			receive_full_flag_q <= receive_full_flag_d;
			fe_q <= fe_d;
			ovr_q <= ovr_d;
			bdf_q <= bdf_d;
			hdf_q <= hdf_d;
			pe_q <= pe_d;
		end
	end

	assign status = {ovr_q, pe_q, hdf_q, bdf_q, !hold_full_q, tc_q, fe_q, receive_full_flag_q};
	// Single request line, each source gated by its enable
	assign irq = (bdf_q && ctrl_q[lin_uart_pkg::CB_BIE]) || (hdf_q && ctrl_q[lin_uart_pkg::CB_HIE]) ||
		(pe_q && ctrl_q[lin_uart_pkg::CB_PIE]) || (receive_full_flag_q && ctrl_q[lin_uart_pkg::CB_RIE]);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	brk_tx_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(tx_state_q == lin_uart_pkg::TX_BREAK && $rose(txd_q)) |-> brk_lows_q == lin_uart_pkg::BRK_TX_LOW)
		else $error("break low phase not thirteen bits");
	brk_flag_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(bdf_q) |-> $past(bk_found) && $past(lin) && $past(bk_state_q) == lin_uart_pkg::BK_DELIM)
		else $error("break flag without delimiter");
	brk_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(bk_state_q == lin_uart_pkg::BK_COUNT && b_stb && !b_val && zcnt_q == need - 4'h1 &&
		ctrl_q[lin_uart_pkg::CB_REN]) |=> bk_state_q == lin_uart_pkg::BK_DELIM)
		else $error("break length not reached on count");
	brk_cancel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(bk_state_q == lin_uart_pkg::BK_COUNT && b_stb && b_val) |=>
			zcnt_q == 4'h0 && bk_state_q == lin_uart_pkg::BK_COUNT && !b_stb)
		else $error("high bit did not cancel break search");
	rx_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(rx_state_q == lin_uart_pkg::RX_HALT && lin && !bk_cancel && !bk_found) |=>
			rx_state_q == lin_uart_pkg::RX_HALT && !d_stb)
		else $error("receiver left halt without break result");
	brk_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(bdf_q && ctrl_q[lin_uart_pkg::CB_BIE]) |-> irq)
		else $error("break interrupt missing");
	hdr_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(hdf_q) |-> $past(lin_slave) && $past(hdr_ph_q) == lin_uart_pkg::HDR_ID &&
			rx_data_q == $past(rx_sh_q))
		else $error("header flag without identifier");
	pe_with_hdr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(pe_q) |-> hdf_q && $past(id_done) && $past(ctrl_q[lin_uart_pkg::CB_PARITY_CHECK_ENABLE]))
		else $error("parity flag apart from header flag");
	mute_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(char_done && muted && !receive_full_flag_q && !fe_q) |=> !receive_full_flag_q && !fe_q)
		else $error("muted receiver delivered a character");
endmodule

// File: logic/lin_uart_pkg.sv
package lin_uart_pkg;
	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_BAUD = 8'h0C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register fields
	localparam int CB_LIN = 0;
	localparam int CB_TEN = 1;
	localparam int CB_REN = 2;
	localparam int CB_SBK = 3;
	localparam int CB_BLEN = 4;
	localparam int CB_BIE = 5;
	localparam int CB_RIE = 6;
	localparam int CB_HIE = 7;
	localparam int CB_FOLLOW = 8;
	localparam int CB_MUTE = 9;
	localparam int CB_PARITY_CHECK_ENABLE = 10;
	localparam int CB_PIE = 11;
	localparam logic [11:0] CTRL_RESET = 12'h000;
	localparam logic [15:0] BAUD_RESET = 16'h000A;

	// Status register fields; write one clears the W1C set
	localparam int ST_RECEIVE_FULL_FLAG = 0;
	localparam int ST_FE = 1;
	localparam int ST_TC = 2;
	localparam int ST_TXE = 3;
	localparam int ST_BDF = 4;
	localparam int ST_HDF = 5;
	localparam int ST_PE = 6;
	localparam int ST_OVR = 7;
	localparam logic [7:0] ST_W1C = 8'hF2;

	// ----------------------------------------
	// Bit timing and framing
	// ----------------------------------------
	localparam logic [3:0] SAMP_FIRST = 4'h7;
	localparam logic [3:0] SAMP_MID = 4'h8;
	localparam logic [3:0] SAMP_LAST = 4'h9;
	localparam logic [3:0] PHASE_END = 4'hF;
	localparam logic [3:0] BRK_TX_LOW = 4'hD;
	localparam logic [3:0] BRK_TX_BITS = 4'hE;
	localparam logic [3:0] CHAR_BITS = 4'hA;
	localparam logic [3:0] STOP_IDX = 4'h9;
	localparam logic [3:0] BRK_SHORT = 4'hA;
	localparam logic [3:0] BRK_LONG = 4'hB;
	localparam logic [7:0] SYNCH_BYTE = 8'h55;
	localparam logic [1:0] HDR_NONE = 2'h0;
	localparam logic [1:0] HDR_SYNCH = 2'h1;
	localparam logic [1:0] HDR_ID = 2'h2;

	typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_BREAK = 3'b010, TX_CHAR = 3'b100} tx_state_t;
	typedef enum logic [1:0] {RX_RUN = 2'b01, RX_HALT = 2'b10} rx_state_t;
	typedef enum logic [1:0] {BK_COUNT = 2'b01, BK_DELIM = 2'b10} bk_state_t;
	typedef enum logic [1:0] {SM_IDLE = 2'b01, SM_RUN = 2'b10} sm_state_t;
endpackage

// File: verif/lin_node.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far node on the shared bus
// ----------------------------------------
module lin_node #(
	parameter int BIT_CLKS = 16
) (
	input wire logic aclk,
	output logic line_tx
);
	// Released line rests at the pull-up level
	initial line_tx = 1'h1;

	// One level held for whole bit times; callers end on a high bit to release
	task automatic send_bits(input logic v, input int nb);
	begin
		line_tx <= v;
		repeat (nb * BIT_CLKS) @(posedge aclk);
	end
	endtask

	// Start, eight data bits LSB first, one stop, no parity
	task automatic send_byte(input logic [7:0] b);
	begin
		send_bits(1'h0, 1);
		for (int i = 0; i < 8; i++) send_bits(b[i], 1);
		send_bits(1'h1, 1);
	end
	endtask

	// Header as a bus master sends it
	task automatic send_header(input logic [7:0] pid);
	begin
		send_bits(1'h0, 13);
		send_bits(1'h1, 1);
		send_byte(lin_uart_pkg::SYNCH_BYTE);
		send_byte(pid);
	end
	endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %0t got %h want %h", $time, g, e); end end
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb_top;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, pid, b;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, rd, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, txd, irq, node_tx;
	logic [1:0] bresp, rresp;
	logic [31:0] brk_ctrl [3] = '{32'h7, 32'h17, 32'h6};
	int brk_low [3] = '{10, 10, 13};
	int miscompares = 0, tests_run = 0, seed = 70, n;
	// Single wire: either node pulls it dominant
	wire rxd = txd & node_tx;

	lin_uart DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .rxd, .txd, .irq);
	lin_node #(.BIT_CLKS(16)) node (.aclk(aclk), .line_tx(node_tx));

	// 50 ns clock
	initial forever #25 aclk = ~aclk;

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_hs, w_hs, b_hs;
	begin
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		n = 0;
		do
		begin
			// Handshakes judged on settled values, acted on at the next edge
			@(negedge aclk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			b_hs = bvalid && bready;
			@(posedge aclk);
			if (aw_hs) awvalid <= 1'h0;
			if (w_hs) wvalid <= 1'h0;
			n++;
		end
		while (b_hs !== 1'h1 && n < 500);
		bready <= 1'h0;
		if (b_hs !== 1'h1)
		begin
			miscompares++;
			$display("[ERR] %0t write not answered", $time);
		end
	end
	endtask

	task automatic rd_reg(input logic [7:0] a);
		logic ar_hs, r_hs;
	begin
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do
		begin
			@(negedge aclk);
			ar_hs = arvalid && arready;
			r_hs = rvalid && rready;
			if (r_hs) rd = rdata;
			@(posedge aclk);
			if (ar_hs) arvalid <= 1'h0;
			n++;
		end
		while (r_hs !== 1'h1 && n < 500);
		rready <= 1'h0;
		if (r_hs !== 1'h1)
		begin
			miscompares++;
			$display("[ERR] %0t read not answered", $time);
		end
	end
	endtask

	// Poll status until a flag shows; bounded so a hang cannot stall it
	task automatic wait_st(input int f);
		int k;
	begin
		k = 0;
		do
		begin
			rd_reg(lin_uart_pkg::OFS_STATUS);
			k++;
		end
		while (rd[f] !== 1'h1 && k < 400);
		if (rd[f] !== 1'h1)
		begin
			miscompares++;
			$display("[ERR] %0t status flag %0d never set", $time, f);
		end
	end
	endtask

	function automatic logic [7:0] prot_id(input logic [5:0] id);
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction

	task automatic final_report;
	begin
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	// Watchdog, several times the expected run length
	initial
	begin
		repeat (60000) @(posedge aclk);
		miscompares++;
		final_report;
	end

	// Main sequence
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		rd_reg(lin_uart_pkg::OFS_STATUS);
		`CHK(rd[7:0], 8'h0C)
		rd_reg(8'h10);
		`CHK(rresp, lin_uart_pkg::RESP_SLVERR)
		wr(lin_uart_pkg::OFS_BAUD, 32'h0);
		// Own break: low width, echoed flags, interrupt
		wr(lin_uart_pkg::OFS_CTRL, 32'h2F);
		n = 0;
		while (txd !== 1'h0 && n < 50)
		begin
			@(negedge aclk);
			n++;
		end
		n = 0;
		while (txd === 1'h0 && n < 300)
		begin
			@(negedge aclk);
			n++;
		end
		`CHK(n, 13 * 16)
		wait_st(lin_uart_pkg::ST_BDF);
		`CHK(rd[2:0] & 3'h3, 3'h3)
		`CHK(irq, 1'h1)
		rd_reg(lin_uart_pkg::OFS_DATA);
		wr(lin_uart_pkg::OFS_STATUS, 32'hF2);
		`CHK(irq, 1'h0)
		// Response bytes read back as echoes
		repeat (3)
		begin
			b = 8'($random(seed));
			wr(lin_uart_pkg::OFS_DATA, {24'h0, b});
			wait_st(lin_uart_pkg::ST_RECEIVE_FULL_FLAG);
			rd_reg(lin_uart_pkg::OFS_DATA);
			`CHK(rd[7:0], b)
		end
		// Breaks: ten lows pass only the short length, thirteen pass none without the protocol
		for (int c = 0; c < 3; c++)
		begin
			wr(lin_uart_pkg::OFS_CTRL, brk_ctrl[c]);
			node.send_bits(1'h0, brk_low[c]);
			node.send_bits(1'h1, 3);
			rd_reg(lin_uart_pkg::OFS_STATUS);
			`CHK(rd[lin_uart_pkg::ST_BDF], 1'(c == 0))
			wr(lin_uart_pkg::OFS_STATUS, 32'hF2);
			rd_reg(lin_uart_pkg::OFS_DATA);
		end
		// Muted follower: plain byte dropped, header wakes it, bad parity on odd passes
		for (int i = 0; i < 4; i++)
		begin
			wr(lin_uart_pkg::OFS_CTRL, 32'hF86);
			wr(lin_uart_pkg::OFS_CTRL, 32'hF87);
			pid = prot_id(6'($random(seed))) ^ {i[0], 7'h0};
			node.send_byte(8'hA5);
			rd_reg(lin_uart_pkg::OFS_STATUS);
			`CHK(rd[lin_uart_pkg::ST_RECEIVE_FULL_FLAG], 1'h0)
			fork
				node.send_header(pid);
			join_none
			wait_st(lin_uart_pkg::ST_HDF);
			`CHK(rd[lin_uart_pkg::ST_PE], i[0])
			`CHK(irq, 1'h1)
			rd_reg(lin_uart_pkg::OFS_DATA);
			`CHK(rd[7:0], pid)
			rd_reg(lin_uart_pkg::OFS_CTRL);
			`CHK(rd[lin_uart_pkg::CB_MUTE], 1'h0)
			wait fork;
			wr(lin_uart_pkg::OFS_STATUS, 32'hF2);
		end
		final_report;
	end
endmodule
